//--- src/ddrrq_top.sv
// request and data path between local user port and memory phy
`timescale 1ns/1ps
`include "ddrrq_defines.svh"
module ddrrq_top #(
  parameter int BANK_W = `DDRRQ_BANK_W,
  parameter int ROW_W = `DDRRQ_ROW_W,
  parameter int LCOL_W = `DDRRQ_LCOL_W,
  parameter int DATA_W = `DDRRQ_DATA_W,
  parameter int QDEPTH = `DDRRQ_QDEPTH,
  parameter int ECC_LAT = `DDRRQ_ECC_LAT,
  parameter int AW = BANK_W + ROW_W + LCOL_W,
  parameter int MCOL_W = LCOL_W + `DDRRQ_COL_SHIFT
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // local request side
  input wire logic i_local_rd_req,
  input wire logic i_local_wr_req,
  input wire ddrrq_pkg::ddrrq_size_t i_local_size,
  input wire logic [AW-1:0] i_local_addr,
  input wire logic [DATA_W-1:0] i_local_wdata,
  input wire logic [DATA_W/8-1:0] i_local_be,
  output logic o_local_ready,
  // local read return
  output logic [DATA_W-1:0] o_local_rdata,
  output logic o_local_rdata_valid,
  // phy command and write side
  output logic o_phy_cmd_valid,
  output logic o_phy_cmd_wr,
  output logic [BANK_W-1:0] o_phy_bank,
  output logic [ROW_W-1:0] o_phy_row,
  output logic [MCOL_W-1:0] o_phy_col,
  output logic [DATA_W-1:0] o_phy_wdata,
  output logic [DATA_W/8-1:0] o_phy_be,
  output logic o_phy_wdata_valid,
  output logic o_phy_dqs_burst,
  output logic o_phy_doing_rd,
  // phy read return
  input wire logic [DATA_W-1:0] i_phy_rdata,
  input wire logic i_phy_rdata_valid
);
  import ddrrq_pkg::*;

  localparam int AB = `DDRRQ_ALIGN_BITS;
  localparam int QW = 2 + 2 + AW + DATA_W + DATA_W / 8;

  // ----------------------------------------------------------------
  // request acceptance
  // ----------------------------------------------------------------
  logic q_full, q_empty, q_pop, q_push, accept;
  logic [QW-1:0] q_in, q_out;
  ddrrq_size_t beats_left_r, beats_left_nxt;
  logic is_first;

  assign o_local_ready = !q_full && !i_reset;
  assign accept = o_local_ready && (i_local_rd_req || i_local_wr_req);
  assign q_push = accept;
  // later beats of a multi-beat write carry data only
  assign is_first = (beats_left_r == 2'h0);
  assign q_in = {i_local_wr_req, is_first, i_local_size, i_local_addr,
                 i_local_wdata, i_local_be};

  always_comb begin
    beats_left_nxt = beats_left_r;
    if (accept && i_local_wr_req) begin
      if (is_first) begin
        // size zero is treated as a single beat
        beats_left_nxt = (i_local_size == 2'h0) ? 2'h0 :
                         i_local_size - 2'h1;
      end else begin
        beats_left_nxt = beats_left_r - 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      beats_left_r <= 2'h0;
    end else begin
      beats_left_r <= beats_left_nxt;
    end
  end

  ddrrq_cmd_queue #(
    .W(QW),
    .DEPTH(QDEPTH)
  ) u_queue (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_push(q_push),
    .i_data(q_in),
    .o_full(q_full),
    .i_pop(q_pop),
    .o_data(q_out),
    .o_empty(q_empty)
  );

  // ----------------------------------------------------------------
  // head decode and address map
  // ----------------------------------------------------------------
  logic h_wr;
  ddrrq_size_t h_size;
  logic [AW-1:0] h_addr;
  logic [DATA_W-1:0] h_wdata;
  logic [DATA_W/8-1:0] h_be;
  logic [MCOL_W-1:0] h_col;
  logic h_first;

  assign h_wr = q_out[QW-1];
  assign h_first = q_out[QW-2];
  assign h_size = q_out[QW-3 -: 2];
  assign h_addr = q_out[QW-5 -: AW];
  assign h_wdata = q_out[DATA_W/8 +: DATA_W];
  assign h_be = q_out[DATA_W/8-1:0];
  assign h_col = {h_addr[LCOL_W-1:0], 2'h0};

  // ----------------------------------------------------------------
  // sequencer toward the phy
  // ----------------------------------------------------------------
  ddrrq_state_t state_r, state_nxt;
  ddrrq_size_t left_r, left_nxt;
  logic cmd_v_nxt, cmd_wr_nxt, wdv_nxt, dqs_nxt, doing_nxt;
  logic [BANK_W-1:0] bank_nxt;
  logic [ROW_W-1:0] row_nxt;
  logic [MCOL_W-1:0] col_nxt, wcol_r, wcol_nxt;
  logic [DATA_W-1:0] wdata_nxt;
  logic [DATA_W/8-1:0] be_nxt;

  always_comb begin
    state_nxt = state_r;
    left_nxt = left_r;
    wcol_nxt = wcol_r;
    q_pop = 1'b0;
    cmd_v_nxt = 1'b0;
    cmd_wr_nxt = o_phy_cmd_wr;
    bank_nxt = o_phy_bank;
    row_nxt = o_phy_row;
    col_nxt = o_phy_col;
    wdata_nxt = o_phy_wdata;
    be_nxt = o_phy_be;
    wdv_nxt = 1'b0;
    doing_nxt = 1'b0;
    case (state_r)
      DDRRQ_ST_IDLE: begin
        if (!q_empty) begin
          q_pop = 1'b1;
          cmd_v_nxt = 1'b1;
          cmd_wr_nxt = h_wr;
          bank_nxt = h_addr[AW-1 -: BANK_W];
          row_nxt = h_addr[LCOL_W +: ROW_W];
          col_nxt = h_col;
          left_nxt = (h_size == 2'h0) ? 2'h1 : h_size;
          if (h_wr) begin
            wdata_nxt = h_wdata;
            be_nxt = h_be;
            wdv_nxt = 1'b1;
            left_nxt = left_nxt - 2'h1;
            wcol_nxt = h_col;
            state_nxt = DDRRQ_ST_WR;
          end else begin
            doing_nxt = 1'b1;
            state_nxt = DDRRQ_ST_RD;
          end
        end
      end
      DDRRQ_ST_RD: begin
        if (left_r > 2'h1) begin
          doing_nxt = 1'b1;
          left_nxt = left_r - 2'h1;
        end else begin
          state_nxt = DDRRQ_ST_IDLE;
        end
      end
      DDRRQ_ST_WR: begin
        if (left_r != 2'h0) begin
          // a gap in user beats stalls here with dqs kept framed
          if (!q_empty) begin
            q_pop = 1'b1;
            wdata_nxt = h_wdata;
            be_nxt = h_be;
            wdv_nxt = 1'b1;
            left_nxt = left_r - 2'h1;
          end
        end else begin
          if (wcol_r[AB-1:0] != '0) begin
            cmd_v_nxt = 1'b1;
            cmd_wr_nxt = 1'b1;
            col_nxt = {wcol_r[MCOL_W-1:AB] + 1'b1, {AB{1'b0}}};
          end
          state_nxt = DDRRQ_ST_IDLE;
        end
      end
      default: begin
        state_nxt = DDRRQ_ST_IDLE;
      end
    endcase
    dqs_nxt = wdv_nxt || (state_nxt == DDRRQ_ST_WR && left_nxt != 2'h0);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r <= DDRRQ_ST_IDLE;
      left_r <= 2'h0;
      wcol_r <= '0;
      o_phy_cmd_valid <= `DDRRQ_RST_BIT;
      o_phy_cmd_wr <= `DDRRQ_RST_BIT;
      o_phy_bank <= '0;
      o_phy_row <= '0;
      o_phy_col <= '0;
      o_phy_wdata <= '0;
      o_phy_be <= '0;
      o_phy_wdata_valid <= `DDRRQ_RST_BIT;
      o_phy_dqs_burst <= `DDRRQ_RST_BIT;
      o_phy_doing_rd <= `DDRRQ_RST_BIT;
    end else begin
      state_r <= state_nxt;
      left_r <= left_nxt;
      wcol_r <= wcol_nxt;
      o_phy_cmd_valid <= cmd_v_nxt;
      o_phy_cmd_wr <= cmd_wr_nxt;
      o_phy_bank <= bank_nxt;
      o_phy_row <= row_nxt;
      o_phy_col <= col_nxt;
      o_phy_wdata <= wdata_nxt;
      o_phy_be <= be_nxt;
      o_phy_wdata_valid <= wdv_nxt;
      o_phy_dqs_burst <= dqs_nxt;
      o_phy_doing_rd <= doing_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read return, optional ecc latency
  // ----------------------------------------------------------------
  generate
    if (ECC_LAT == 0) begin : g_pass
      // zero delay means this path is combinational from the phy
      assign o_local_rdata = i_phy_rdata;
      assign o_local_rdata_valid = i_phy_rdata_valid && !i_reset;
    end else begin : g_ecc
      logic [DATA_W-1:0] d_r [ECC_LAT];
      logic [ECC_LAT-1:0] v_r, v_nxt;
      always_comb begin
        v_nxt = v_r << 1;
        v_nxt[0] = i_phy_rdata_valid;
      end
      always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
          v_r <= '0;
        end else begin
          v_r <= v_nxt;
        end
      end
      always_ff @(posedge i_clk_sys) begin
        d_r[0] <= i_phy_rdata;
        for (int k = 1; k < ECC_LAT; k++) begin
          d_r[k] <= d_r[k-1];
        end
      end
      assign o_local_rdata = d_r[ECC_LAT-1];
      assign o_local_rdata_valid = v_r[ECC_LAT-1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_full_refuses: assert property (@(posedge i_clk_sys)
    q_full |-> !o_local_ready)
    else $error("ready high while queue full");
  // ready is combinational, so it is already low while reset is still applied
  a_reset_quiet: assert property (@(posedge i_clk_sys)
    i_reset |-> !o_local_ready ##1 (!o_phy_wdata_valid && !o_phy_doing_rd
    && !o_phy_cmd_valid))
    else $error("strobes active after reset");
  a_beat_order: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    q_pop |-> h_first == (state_r == DDRRQ_ST_IDLE))
    else $error("write beats out of order in queue");
  a_col_shifted: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_phy_cmd_valid |-> o_phy_col[1:0] == 2'h0)
    else $error("memory column not shifted by two");
  a_rd_len_two: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    q_pop && state_r == DDRRQ_ST_IDLE && !h_wr && h_size == 2'h2
    |=> o_phy_cmd_valid && o_phy_doing_rd ##1 o_phy_doing_rd
    ##1 !o_phy_doing_rd)
    else $error("read-in-progress length wrong for size two");
  a_wdv_dqs: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_phy_wdata_valid |-> o_phy_dqs_burst)
    else $error("write data valid outside dqs burst");
  a_wr_cmd_data: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_phy_cmd_valid && o_phy_cmd_wr && state_r == DDRRQ_ST_WR && left_r != 2'h0
    |-> o_phy_wdata_valid)
    else $error("write command without first data beat");
  a_unaligned_extra: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == DDRRQ_ST_WR && left_r == 2'h0 && wcol_r[AB-1:0] != '0
    |=> o_phy_cmd_valid && o_phy_cmd_wr && o_phy_col[AB-1:0] == '0
    && o_phy_col[MCOL_W-1:AB] == $past(wcol_r[MCOL_W-1:AB]) + 1'b1)
    else $error("no extra burst at next aligned column");
  a_rd_return: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_local_rdata_valid == $past(i_phy_rdata_valid, ECC_LAT == 0 ? 1 : ECC_LAT)
    || ECC_LAT == 0)
    else $error("local read valid misaligned with phy");
  a_rd_zero_lat: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ECC_LAT == 0 && i_phy_rdata_valid |-> o_local_rdata_valid
    && o_local_rdata == i_phy_rdata)
    else $error("read data delayed without ecc");
  c_read: cover property (@(posedge i_clk_sys) o_phy_cmd_valid && !o_phy_cmd_wr);
  c_extra: cover property (@(posedge i_clk_sys)
    state_r == DDRRQ_ST_WR && left_r == 2'h0 && wcol_r[AB-1:0] != '0);
  c_full: cover property (@(posedge i_clk_sys) q_full && i_local_rd_req);
  c_rvalid: cover property (@(posedge i_clk_sys) o_local_rdata_valid);
endmodule // ddrrq_top

//--- src/ddrrq_defines.svh
// constants for the sdram request and data path
`ifndef DDRRQ_DEFINES_SVH
`define DDRRQ_DEFINES_SVH
`define DDRRQ_COL_SHIFT 2
`define DDRRQ_ALIGN_BITS 3
`define DDRRQ_QDEPTH 8
`define DDRRQ_ECC_LAT 0
`define DDRRQ_BANK_W 3
`define DDRRQ_ROW_W 13
`define DDRRQ_LCOL_W 11
`define DDRRQ_DATA_W 32
`define DDRRQ_RST_BIT 1'b0
`endif

//--- src/ddrrq_pkg.sv
// types shared by the sdram request and data path
package ddrrq_pkg;
  typedef logic [1:0] ddrrq_size_t;
  typedef enum logic [2:0] {
    DDRRQ_ST_IDLE = 3'b001,
    DDRRQ_ST_RD = 3'b010,
    DDRRQ_ST_WR = 3'b100
  } ddrrq_state_t;
endpackage

//--- src/ddrrq_cmd_queue.sv
// show-ahead command queue with honest full and empty
`timescale 1ns/1ps
module ddrrq_cmd_queue #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // fill side
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  output logic o_full,
  // drain side
  input wire logic i_pop,
  output logic [W-1:0] o_data,
  output logic o_empty
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic do_push, do_pop;

  assign o_empty = (wp_r == rp_r);
  assign o_full = (wp_r[PW-1:0] == rp_r[PW-1:0]) && (wp_r[PW] != rp_r[PW]);
  assign do_push = i_push && !o_full;
  assign do_pop = i_pop && !o_empty;
  assign o_data = mem[rp_r[PW-1:0]];

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (do_push) begin
      wp_nxt = wp_r + 1'b1;
    end
    if (do_pop) begin
      rp_nxt = rp_r + 1'b1;
    end
  end

  // reset empties the queue, dropping anything pending
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (do_push) begin
      mem[wp_r[PW-1:0]] <= i_data;
    end
  end

  a_push_fills: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    do_push && !do_pop |=> !o_empty)
    else $error("accepted entry not held in queue");
  a_reset_empty: assert property (@(posedge i_clk_sys)
    i_reset |=> o_empty && !o_full)
    else $error("queue not emptied by reset");
endmodule // ddrrq_cmd_queue

//--- dv/ddrrq_phy_model.sv
// phy-side partner model: read capture window and read return
`timescale 1ns/1ps
module ddrrq_phy_model #(
  parameter int LAT = 4
) (
  // clock
  input wire logic i_clk_sys,
  // controller framing
  input wire logic i_doing_rd,
  // write side from the controller
  input wire logic i_wdata_valid,
  input wire logic i_dqs_burst,
  // read return
  output logic [31:0] o_rdata,
  output logic o_rdata_valid,
  // beats sent toward memory
  output logic [7:0] o_wr_beats
);
  logic [LAT-1:0] pipe_r;
  logic [31:0] word_r;
  initial begin
    pipe_r = '0;
    word_r = 32'h5a000000;
    o_rdata = 32'h0;
    o_rdata_valid = 1'b0;
    o_wr_beats = 8'h0;
  end
  // a beat only leaves for memory when dqs is framed around it
  always @(posedge i_clk_sys) begin
    if (i_wdata_valid && i_dqs_burst) begin
      o_wr_beats <= o_wr_beats + 8'h1;
    end
  end
  // capture runs only inside the window the controller frames
  always @(posedge i_clk_sys) begin
    pipe_r <= {pipe_r[LAT-2:0], i_doing_rd};
    if (pipe_r[LAT-1]) begin
      word_r <= word_r + 32'h1;
      o_rdata <= word_r;
      o_rdata_valid <= 1'b1;
    end else begin
      // an idle bus inverts each cycle, so only odd idle cycles differ from the last word
      o_rdata <= ~o_rdata;
      o_rdata_valid <= 1'b0;
    end
  end
endmodule // ddrrq_phy_model

//--- dv/ddrrq_top_tb.sv
// self-checking bench for the sdram request and data path
`timescale 1ns/1ps
module ddrrq_top_tb;
  logic i_clk_sys, i_reset, rd_req, wr_req, ready, rvalid, phy_rv;
  logic cmd_v, cmd_wr, wdv, dqs, doing;
  logic [1:0] size;
  logic [26:0] addr;
  logic [31:0] wdata, rdata, wdat, phy_rd;
  logic [3:0] be, pbe;
  logic [2:0] bank;
  logic [12:0] row, col;
  logic [7:0] wr_beats;
  int error_cnt = 0;
  int checks = 0;
  int rv_cnt = 0;
  ddrrq_top dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_local_rd_req(rd_req), .i_local_wr_req(wr_req),
    .i_local_size(size), .i_local_addr(addr), .i_local_wdata(wdata),
    .i_local_be(be), .o_local_ready(ready), .o_local_rdata(rdata),
    .o_local_rdata_valid(rvalid), .o_phy_cmd_valid(cmd_v),
    .o_phy_cmd_wr(cmd_wr), .o_phy_bank(bank), .o_phy_row(row),
    .o_phy_col(col), .o_phy_wdata(wdat), .o_phy_be(pbe),
    .o_phy_wdata_valid(wdv), .o_phy_dqs_burst(dqs),
    .o_phy_doing_rd(doing), .i_phy_rdata(phy_rd),
    .i_phy_rdata_valid(phy_rv));
  ddrrq_phy_model phy (.i_clk_sys(i_clk_sys), .i_doing_rd(doing),
    .i_wdata_valid(wdv), .i_dqs_burst(dqs),
    .o_rdata(phy_rd), .o_rdata_valid(phy_rv), .o_wr_beats(wr_beats));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize;
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // called at a falling edge; holds everything until the beat is taken
  task automatic put(input logic rd, input logic [26:0] a,
                     input logic [1:0] s, input logic [31:0] d);
    logic took;
    took = 1'b0;
    rd_req = rd;
    wr_req = !rd;
    addr = a;
    size = s;
    wdata = d;
    be = d[3:0];
    while (!took) begin
      #1;
      took = (ready === 1'b1);
      @(negedge i_clk_sys);
    end
  endtask
  task automatic wait_cmd;
    int n;
    n = 0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    while (cmd_v !== 1'b1 && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk("cmd_valid", cmd_v, 1'b1);
  endtask
  // local read side must mirror the phy word for word, no added delay
  always @(negedge i_clk_sys) begin
    if (i_reset) begin
      chk("rdata_valid in reset", rvalid, 1'b0);
    end else begin
      chk("rdata_valid", rvalid, phy_rv);
      if (phy_rv === 1'b1) begin
        rv_cnt++;
        chk("rdata", rdata, phy_rd);
      end
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_read;
    int n;
    n = 0;
    rv_cnt = 0;
    put(1'b1, {3'h3, 13'h1, 11'h2}, 2'd2, 32'h0);
    wait_cmd();
    chk("cmd_wr", cmd_wr, 1'b0);
    chk("bank", bank, 3'h3);
    chk("row", row, 13'h1);
    chk("col", col, 13'h8);
    while (doing === 1'b1 && n < 10) begin
      n++;
      @(negedge i_clk_sys);
    end
    chk("doing_rd cycles", n, 2);
    repeat (8) @(negedge i_clk_sys);
    chk("read words", rv_cnt, 2);
    // size zero is taken as a single beat
    put(1'b1, 27'h0, 2'd0, 32'h0);
    wait_cmd();
    n = 0;
    while (doing === 1'b1 && n < 10) begin
      n++;
      @(negedge i_clk_sys);
    end
    chk("doing_rd size zero", n, 1);
  endtask
  task automatic t_write;
    int n;
    n = 0;
    put(1'b0, {3'h0, 13'h0, 11'h1}, 2'd2, 32'hcafe0001);
    put(1'b0, {3'h0, 13'h0, 11'h1}, 2'd2, 32'hcafe0002);
    wait_cmd();
    chk("cmd_wr", cmd_wr, 1'b1);
    chk("wr col", col, 13'h4);
    chk("wdata_valid", wdv, 1'b1);
    chk("wdata0", wdat, 32'hcafe0001);
    chk("be0", pbe, 4'h1);
    chk("dqs_burst", dqs, 1'b1);
    @(negedge i_clk_sys);
    chk("wdata_valid beat1", wdv, 1'b1);
    chk("wdata1", wdat, 32'hcafe0002);
    chk("be1", pbe, 4'h2);
    chk("dqs_burst beat1", dqs, 1'b1);
    @(negedge i_clk_sys);
    chk("extra burst", cmd_v, 1'b1);
    chk("extra col", col, 13'h8);
    chk("extra wr", cmd_wr, 1'b1);
    chk("dqs_burst end", dqs, 1'b0);
    put(1'b0, 27'h0, 2'd1, 32'hbeef0004);
    wait_cmd();
    chk("aligned col", col, 13'h0);
    repeat (4) begin
      @(negedge i_clk_sys);
      n += (cmd_v === 1'b1);
    end
    chk("no extra burst", n, 0);
    chk("beats sent with dqs", wr_beats, 8'd3);
  endtask
  task automatic t_full_reset;
    int n;
    n = 0;
    rd_req = 1'b1;
    size = 2'd3;
    #1;
    chk("ready with room", ready, 1'b1);
    while (ready === 1'b1 && n < 20) begin
      @(negedge i_clk_sys);
      n++;
      addr = 27'(n);
      #1;
    end
    chk("ready when full", ready, 1'b0);
    @(negedge i_clk_sys);
    i_reset = 1'b1;
    #1;
    chk("ready in reset", ready, 1'b0);
    @(negedge i_clk_sys);
    chk("cmd in reset", cmd_v, 1'b0);
    chk("doing in reset", doing, 1'b0);
    chk("wdv in reset", wdv, 1'b0);
    i_reset = 1'b0;
    rd_req = 1'b0;
    n = 0;
    repeat (6) begin
      @(negedge i_clk_sys);
      n += (cmd_v === 1'b1) + (doing === 1'b1);
    end
    chk("queue dropped", n, 0);
    chk("ready after reset", ready, 1'b1);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #(50 * 3000);
    error_cnt++;
    summarize();
  end
  initial begin
    i_reset = 1'b1;
    rd_req = 1'b0;
    wr_req = 1'b0;
    size = 2'd0;
    addr = 27'h0;
    wdata = 32'h0;
    be = 4'h0;
    repeat (12) @(negedge i_clk_sys);
    chk("ready held in reset", ready, 1'b0);
    i_reset = 1'b0;
    @(negedge i_clk_sys);
    t_read();
    t_write();
    t_full_reset();
    summarize();
  end
endmodule // ddrrq_top_tb
